/* File: hdl/sbr_pkg.sv */
// constants, types and carriers shared by the synchronous block ram tile
package sbr_pkg;

   // ****************************************
   // storage geometry
   // ****************************************
   localparam int DATA_BITS   = 8192;             // plain data capacity
   localparam int TOTAL_BITS  = 9216;             // capacity with parity positions
   localparam int LANE_W      = 9;                // one byte plus its parity bit
   localparam int LANES       = TOTAL_BITS / LANE_W;
   localparam int ADDR_W      = 13;
   localparam int DATA_W      = 36;
   localparam int BE_W        = 4;
   localparam int SHAPES      = 9;
   localparam int LOAD_CYCLES = LANES;            // one lane preloaded per cycle

   // shape table, index 0..8: 8192x1 up to 256x36
   localparam int SHAPE_WIDTH [0:SHAPES-1] = '{1, 2, 4, 8, 9, 16, 18, 32, 36};
   localparam int SHAPE_DLOG  [0:SHAPES-1] = '{13, 12, 11, 10, 10, 9, 9, 8, 8};
   localparam int SHAPE_SUB   [0:SHAPES-1] = '{3, 2, 1, 0, 0, 0, 0, 0, 0};
   localparam int SHAPE_LPW   [0:SHAPES-1] = '{0, 0, 0, 0, 0, 1, 1, 2, 2};
   localparam int SHAPE_PAR   [0:SHAPES-1] = '{0, 0, 0, 0, 1, 0, 1, 0, 1};

   // operating modes
   typedef enum logic [2:0] {
      SBR_SP     = 3'h0,
      SBR_SDP    = 3'h1,
      SBR_TDP    = 3'h2,
      SBR_SHIFT  = 3'h3,
      SBR_ROM    = 3'h4,
      SBR_FIFO   = 3'h5,
      SBR_PACKED = 3'h6
   } sbrMode_e;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0]  CTRL_OFS       = 8'h00;
   localparam logic [7:0]  STATUS_OFS     = 8'h04;
   localparam int          CTRL_MODE_LSB  = 0;
   localparam int          CTRL_SHAPE_LSB = 4;
   localparam int          CTRL_NEW_BIT   = 8;
   localparam int          CTRL_OLD_BIT   = 9;
   localparam int          CTRL_LOAD_BIT  = 10;
   localparam int          CTRL_TAP_LSB   = 16;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0382;
   localparam int          STAT_EMPTY_BIT = 0;
   localparam int          STAT_FULL_BIT  = 1;
   localparam int          STAT_READY_BIT = 2;
   localparam int          STAT_COUNT_LSB = 16;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam logic [35:0] DONT_CARE_WORD = 36'hF_FFFF_FFFF;

   // one port's request as the fabric presents it
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [BE_W-1:0]   be;
      logic              rden;
      logic              wren;
      logic              ceIn;
      logic              ceOut;
   } sbrPortReq_s;

endpackage

/* File: hdl/sbr_tile.sv */
// embedded memory tile: two ports, seven modes, nine shapes, axi4-lite setup
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module sbr_tile
   import sbr_pkg::*;
#(
   parameter int                      AXI_AW     = 8,
   parameter logic [TOTAL_BITS-1:0]   INIT_IMAGE = '0
) (
   input  wire logic              clk,         // 10 MHz system clock
   input  wire logic              sys_rst,     // async reset, active high
   input  wire sbrPortReq_s       reqA,        // port a request
   input  wire sbrPortReq_s       reqB,        // port b request
   output logic [DATA_W-1:0]      rdataA,      // port a read data
   output logic [DATA_W-1:0]      rdataB,      // port b read data
   output logic                   tileReady,   // preload finished
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,  // write address
   input  wire logic              s_axi_awvalid, // write address valid
   output logic                   s_axi_awready, // write address ready
   input  wire logic [31:0]       s_axi_wdata,   // write data
   input  wire logic [3:0]        s_axi_wstrb,   // write strobes
   input  wire logic              s_axi_wvalid,  // write data valid
   output logic                   s_axi_wready,  // write data ready
   output logic [1:0]             s_axi_bresp,   // write response
   output logic                   s_axi_bvalid,  // write response valid
   input  wire logic              s_axi_bready,  // write response ready
   input  wire logic [AXI_AW-1:0] s_axi_araddr,  // read address
   input  wire logic              s_axi_arvalid, // read address valid
   output logic                   s_axi_arready, // read address ready
   output logic [31:0]            s_axi_rdata,   // read data
   output logic [1:0]             s_axi_rresp,   // read response
   output logic                   s_axi_rvalid,  // read data valid
   input  wire logic              s_axi_rready   // read data ready
);

   // ****************************************
   // storage and state
   // ****************************************
   logic [LANE_W-1:0] mem [0:LANES-1];   // no reset: write side is never cleared
   logic [31:0]       ctrl_q;
   logic [DATA_W-1:0] rdData_q [0:1];
   logic              ready_q;
   logic [10:0]       loadIdx_q;
   logic [ADDR_W-1:0] shPtr_q;
   logic [ADDR_W-1:0] wrPtr_q;
   logic [ADDR_W-1:0] rdPtr_q;
   logic [ADDR_W:0]   fifoCnt_q;
   logic              awRdy_q, wRdy_q, awHeld_q, wHeld_q, bValid_q, arRdy_q, rValid_q;
   logic [AXI_AW-1:0] awAddr_q;
   logic [31:0]       wData_q, rData_q;
   logic [3:0]        wStrb_q;
   logic [1:0]        bResp_q, rResp_q;

   // ****************************************
   // configuration decode
   // ****************************************
   sbrMode_e          mode;
   logic [3:0]        shapeRaw, shape;
   int                subLog, lpwLog, dLog, nLanes;
   logic              parOn, newOnSame, oldOnMixed, regWrite, reload;
   logic [ADDR_W-1:0] depthMask, halfBit, tapLast;
   logic [ADDR_W:0]   depth;
   logic [DATA_W-1:0] wMask;
   logic              fifoFull, fifoEmpty;

   // shape codes above the table fall back to the widest shape
   always_comb begin
      mode       = sbrMode_e'(ctrl_q[CTRL_MODE_LSB +: 3]);
      shapeRaw   = ctrl_q[CTRL_SHAPE_LSB +: 4];
      shape      = (shapeRaw > 4'(SHAPES-1)) ? 4'(SHAPES-1) : shapeRaw;
      subLog     = SHAPE_SUB[shape];
      lpwLog     = SHAPE_LPW[shape];
      dLog       = SHAPE_DLOG[shape];
      nLanes     = 1 << lpwLog;
      parOn      = (SHAPE_PAR[shape] != 0);
      newOnSame  = ctrl_q[CTRL_NEW_BIT];
      oldOnMixed = ctrl_q[CTRL_OLD_BIT];
      tapLast    = ctrl_q[CTRL_TAP_LSB +: ADDR_W];
      depth      = (ADDR_W+1)'(1) << dLog;
      depthMask  = ADDR_W'(depth - (ADDR_W+1)'(1));
      halfBit    = ADDR_W'(depth >> 1);
      fifoFull   = (fifoCnt_q == depth);
      fifoEmpty  = (fifoCnt_q == '0);
      wMask      = '0;
      if (subLog != 0) begin
         wMask = DATA_W'((36'h1 << SHAPE_WIDTH[shape]) - 36'h1);
      end else begin
         for (int k = 0; k < BE_W; k++) begin
            if (k < nLanes) wMask[k*LANE_W +: LANE_W] = parOn ? 9'h1FF : 9'h0FF;
         end
      end
   end

   // lane that holds the first bit of a word
   function automatic logic [9:0] laneOf(input logic [ADDR_W-1:0] a);
      laneOf = 10'((a >> subLog) << lpwLog);
   endfunction

   // bit offset of a narrow word inside its lane
   function automatic logic [2:0] offOf(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] low;
      low   = a & ADDR_W'((1 << subLog) - 1);
      offOf = 3'(low << (3 - subLog));
   endfunction

   // word as stored before this edge, right aligned, lanes of nine bits
   function automatic logic [DATA_W-1:0] rdVal(input logic [ADDR_W-1:0] a);
      logic [9:0] ln;
      logic [7:0] sb;
      ln    = laneOf(a);
      rdVal = '0;
      sb    = mem[ln][7:0] >> offOf(a);
      if (subLog != 0) begin
         rdVal = DATA_W'(sb);
      end else begin
         for (int k = 0; k < BE_W; k++) begin
            if (k < nLanes) rdVal[k*LANE_W +: LANE_W] = mem[10'(ln + 10'(k))];
         end
      end
      rdVal = rdVal & wMask;
   endfunction

   // ****************************************
   // per-port access decode
   // ****************************************
   sbrPortReq_s       req  [0:1];
   logic [ADDR_W-1:0] addrE [0:1];
   logic              wrE [0:1];
   logic              rdE [0:1];

   always_comb begin
      req[0] = reqA;
      req[1] = reqB;
      for (int p = 0; p < 2; p++) begin
         addrE[p] = req[p].addr & depthMask;
         // no access while input clock enable is low
         wrE[p]   = req[p].wren & req[p].ceIn & ready_q;
         rdE[p]   = req[p].rden & req[p].ceIn & ready_q;
      end
      case (mode)
         SBR_SP: begin
            wrE[1] = 1'b0;
            rdE[1] = 1'b0;
         end
         // simple dual: a writes, b reads
         SBR_SDP: begin
            rdE[0] = 1'b0;
            wrE[1] = 1'b0;
         end
         // both ports read and write freely
         SBR_TDP: begin
         end
         SBR_SHIFT: begin
            addrE[0] = shPtr_q;
            rdE[0]   = wrE[0];
            wrE[1]   = 1'b0;
            rdE[1]   = 1'b0;
         end
         SBR_ROM: begin
            wrE[0] = 1'b0;
            wrE[1] = 1'b0;
         end
         // overflow writes and underflow reads are dropped
         SBR_FIFO: begin
            addrE[0] = wrPtr_q;
            wrE[0]   = wrE[0] & ~fifoFull;
            rdE[0]   = 1'b0;
            addrE[1] = rdPtr_q;
            rdE[1]   = rdE[1] & ~fifoEmpty;
            wrE[1]   = 1'b0;
         end
         // top address bit pins each port to its half
         SBR_PACKED: begin
            addrE[0] = addrE[0] & ~halfBit;
            addrE[1] = addrE[1] | halfBit;
         end
         default: begin
            for (int p = 0; p < 2; p++) begin
               wrE[p] = 1'b0;
               rdE[p] = 1'b0;
            end
         end
      endcase
   end

   // ****************************************
   // storage array
   // ****************************************
   // writes on the rising edge
   // nine-bit lanes hold data and parity
   // port b is applied last, so it wins a same-lane double write
   always_ff @(posedge clk) begin
      if (!ready_q) begin
         mem[loadIdx_q[9:0]] <= INIT_IMAGE[32'(loadIdx_q) * LANE_W +: LANE_W];
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (wrE[p]) begin
               if (subLog != 0) begin
                  if (req[p].be[0]) begin
                     mem[laneOf(addrE[p])][7:0] <= (mem[laneOf(addrE[p])][7:0]
                        & ~(wMask[7:0] << offOf(addrE[p])))
                        | ((req[p].wdata[7:0] & wMask[7:0]) << offOf(addrE[p]));
                  end
               end else begin
                  for (int k = 0; k < BE_W; k++) begin
                     if (k < nLanes && req[p].be[k]) begin
                        mem[10'(laneOf(addrE[p]) + 10'(k))] <=
                           req[p].wdata[k*LANE_W +: LANE_W] & wMask[LANE_W-1:0];
                     end
                  end
               end
            end
         end
      end
   end

   // ****************************************
   // read output registers
   // ****************************************
   logic [DATA_W-1:0] beBits [0:1];
   logic [DATA_W-1:0] rdNext [0:1];

   // choose stored, merged-new or undefined word per port
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < BE_W; k++) begin
            beBits[p][k*LANE_W +: LANE_W] = (subLog != 0) ? {LANE_W{req[p].be[0]}}
                                                          : {LANE_W{req[p].be[k]}};
         end
         rdNext[p] = rdVal(addrE[p]);
         if (wrE[p] && newOnSame && mode != SBR_SHIFT) begin
            rdNext[p] = ((rdNext[p] & ~beBits[p]) | (req[p].wdata & beBits[p])) & wMask;
         end
         if (wrE[1-p] && addrE[1-p] == addrE[p] && !oldOnMixed) begin
            rdNext[p] = DONT_CARE_WORD & wMask;
         end
      end
   end

   // addresses and controls sampled on the edge only
   for (genvar p = 0; p < 2; p++) begin : gRead
      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            rdData_q[p] <= '0;
         end else if (rdE[p] && req[p].ceOut) begin
            // output clock enable gates the register
            rdData_q[p] <= rdNext[p];
         end
      end
   end
   assign rdataA    = rdData_q[0];
   assign rdataB    = rdData_q[1];
   assign tileReady = ready_q;

   // ****************************************
   // preload sequencer
   // ****************************************
   // the tile is dark until every lane holds its image value
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         loadIdx_q <= '0;
         ready_q   <= 1'b0;
      end else if (reload) begin
         loadIdx_q <= '0;
         ready_q   <= 1'b0;
      end else if (!ready_q) begin
         loadIdx_q <= loadIdx_q + 11'h001;
         ready_q   <= (loadIdx_q == 11'(LOAD_CYCLES - 1));
      end
   end

   // ****************************************
   // shift and fifo pointers
   // ****************************************
   // pointers restart on any register write so a new shape starts clean
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         shPtr_q   <= '0;
         wrPtr_q   <= '0;
         rdPtr_q   <= '0;
         fifoCnt_q <= '0;
      end else if (regWrite) begin
         shPtr_q   <= '0;
         wrPtr_q   <= '0;
         rdPtr_q   <= '0;
         fifoCnt_q <= '0;
      end else begin
         if (mode == SBR_SHIFT && wrE[0]) begin
            shPtr_q <= (shPtr_q >= (tapLast & depthMask)) ? '0 : shPtr_q + 13'h0001;
         end
         if (mode == SBR_FIFO) begin
            if (wrE[0]) wrPtr_q <= (wrPtr_q + 13'h0001) & depthMask;
            if (rdE[1]) rdPtr_q <= (rdPtr_q + 13'h0001) & depthMask;
            if (wrE[0] && !rdE[1]) fifoCnt_q <= fifoCnt_q + 14'h0001;
            else if (!wrE[0] && rdE[1]) fifoCnt_q <= fifoCnt_q - 14'h0001;
         end
      end
   end

   // ****************************************
   // axi4-lite register slave
   // ****************************************
   assign regWrite = awHeld_q & wHeld_q & ~bValid_q;
   assign reload   = regWrite && awAddr_q[7:0] == CTRL_OFS && wStrb_q[1]
                     && wData_q[CTRL_LOAD_BIT];

   // write channel: address and data in either order, response after both
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         awRdy_q  <= 1'b1;
         wRdy_q   <= 1'b1;
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         bValid_q <= 1'b0;
         bResp_q  <= RESP_OKAY;
         awAddr_q <= '0;
         wData_q  <= '0;
         wStrb_q  <= '0;
      end else begin
         if (s_axi_awvalid && awRdy_q) begin
            awAddr_q <= s_axi_awaddr;
            awHeld_q <= 1'b1;
            awRdy_q  <= 1'b0;
         end
         if (s_axi_wvalid && wRdy_q) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
            wHeld_q <= 1'b1;
            wRdy_q  <= 1'b0;
         end
         if (regWrite) begin
            bValid_q <= 1'b1;
            bResp_q  <= (awAddr_q[7:0] == CTRL_OFS) ? RESP_OKAY : RESP_SLVERR;
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
         end
         if (bValid_q && s_axi_bready) begin
            bValid_q <= 1'b0;
            awRdy_q  <= 1'b1;
            wRdy_q   <= 1'b1;
         end
      end
   end

   // control register, byte strobes honoured; the reload bit never stores
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RESET;
      end else if (regWrite && awAddr_q[7:0] == CTRL_OFS) begin
         for (int b = 0; b < 4; b++) begin
            if (wStrb_q[b]) ctrl_q[b*8 +: 8] <= wData_q[b*8 +: 8];
         end
         ctrl_q[CTRL_LOAD_BIT] <= 1'b0;
      end
   end

   // read channel: one outstanding read, answered the cycle after arready
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         arRdy_q  <= 1'b1;
         rValid_q <= 1'b0;
         rData_q  <= '0;
         rResp_q  <= RESP_OKAY;
      end else if (s_axi_arvalid && arRdy_q) begin
         arRdy_q  <= 1'b0;
         rValid_q <= 1'b1;
         rResp_q  <= RESP_OKAY;
         rData_q  <= '0;
         if (s_axi_araddr[7:0] == CTRL_OFS) begin
            rData_q <= ctrl_q;
         end else if (s_axi_araddr[7:0] == STATUS_OFS) begin
            rData_q[STAT_EMPTY_BIT]               <= fifoEmpty;
            rData_q[STAT_FULL_BIT]                <= fifoFull;
            rData_q[STAT_READY_BIT]               <= ready_q;
            rData_q[STAT_COUNT_LSB +: ADDR_W + 1] <= fifoCnt_q;
         end else begin
            rResp_q <= RESP_SLVERR;
         end
      end else if (rValid_q && s_axi_rready) begin
         rValid_q <= 1'b0;
         arRdy_q  <= 1'b1;
      end
   end
   assign s_axi_awready = awRdy_q;
   assign s_axi_wready  = wRdy_q;
   assign s_axi_bvalid  = bValid_q;
   assign s_axi_bresp   = bResp_q;
   assign s_axi_arready = arRdy_q;
   assign s_axi_rvalid  = rValid_q;
   assign s_axi_rdata   = rData_q;
   assign s_axi_rresp   = rResp_q;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_read_latency: assert property (rdE[0] && reqA.ceOut |=> rdataA == $past(rdNext[0]))
      else $error("port a read data not one cycle after sample");
   a_ce_hold: assert property (!reqB.ceOut |=> $stable(rdataB))
      else $error("port b output moved with clock enable low");
   a_ce_nowrite: assert property (ready_q && !reqA.ceIn && mode == SBR_SP && subLog == 0
      |=> mem[$past(laneOf(addrE[0]))] == $past(mem[laneOf(addrE[0])]))
      else $error("write took place with input clock enable low");
   a_rom_nowrite: assert property (ready_q && mode == SBR_ROM && subLog == 0
      |=> mem[$past(laneOf(addrE[0]))] == $past(mem[laneOf(addrE[0])]))
      else $error("rom mode changed stored data");
   a_byte_mask: assert property (wrE[0] && !wrE[1] && subLog == 0 && !reqA.be[0]
      |=> mem[$past(laneOf(addrE[0]))] == $past(mem[laneOf(addrE[0])]))
      else $error("disabled byte lane was written");
   a_same_new: assert property (wrE[0] && rdE[0] && reqA.ceOut && newOnSame && !wrE[1]
      && mode == SBR_TDP && reqA.be == 4'hF |=> rdataA == ($past(reqA.wdata) & $past(wMask)))
      else $error("same-port new data not returned");
   a_mixed_old: assert property (wrE[0] && rdE[1] && reqB.ceOut && oldOnMixed && !wrE[1]
      && addrE[0] == addrE[1] |=> rdataB == $past(rdVal(addrE[1])))
      else $error("cross-port old data not returned");
   // dark-cycle counter bounds the preload, a delay range that long would choke the tools
   logic [10:0] darkCnt_q;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         darkCnt_q <= '0;
      end else begin
         darkCnt_q <= ready_q ? 11'h000 : darkCnt_q + 11'h001;
      end
   end
   a_load_done: assert property (darkCnt_q <= 11'(LOAD_CYCLES))
      else $error("preload did not finish in time");
   a_load_quiet: assert property (!ready_q && !$past(ready_q) |-> $stable(rdataA))
      else $error("read output moved while preloading");

endmodule // sbr_tile

/* File: sim/sbr_fabric_model.sv */
// fabric-side partner model driving both memory ports of the tile
`timescale 1ns/1ps
module sbr_fabric_model
   import sbr_pkg::*;
(
   input  wire logic  clk,   // port clock
   output sbrPortReq_s reqA, // port a request
   output sbrPortReq_s reqB  // port b request
);
   // released ports drop read and write enables, keep clock enables, and flip address and data so stale values never pass
   function automatic sbrPortReq_s idle(sbrPortReq_s r);
      idle = r;
      idle.addr = ~r.addr;
      idle.wdata = ~r.wdata;
      idle.rden = 1'b0;
      idle.wren = 1'b0;
   endfunction
   initial begin
      reqA = '0;
      reqB = '0;
   end
   // requests launched just after an edge
   // both ports driven in the same cycle
   task automatic op(input sbrPortReq_s a, input sbrPortReq_s b);
      @(posedge clk);
      reqA <= a;
      reqB <= b;
      @(posedge clk);
      reqA <= idle(a);
      reqB <= idle(b);
   endtask
endmodule // sbr_fabric_model

/* File: sim/sbr_tile_tb_top.sv */
// self-checking testbench of the memory tile
`timescale 1ns/1ps
module sbr_tile_tb_top
   import sbr_pkg::*;
;
   logic clk, sys_rst, tileReady;
   sbrPortReq_s reqA, reqB, nop;
   logic [DATA_W-1:0] rdataA, rdataB, d, pd;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, r;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [12:0] ad, pa = 13'h0000;
   // every lane of the preload image holds the same nine-bit pattern
   localparam logic [DATA_W-1:0] IW = {4{9'h1A5}};
   logic [31:0] sd = 32'h0BBB44C9;
   int num_errors = 0, total_checks = 0;
   sbr_fabric_model fab (.clk, .reqA, .reqB);
   sbr_tile #(.INIT_IMAGE({LANES{9'h1A5}}))
      dut (.clk, .sys_rst, .reqA, .reqB, .rdataA, .rdataB, .tileReady, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // fixed-seed shift register keeps every run repeatable
   function automatic logic [31:0] rnd();
      sd = {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
      return sd;
   endfunction
   function automatic sbrPortReq_s mk(logic [12:0] a, logic [35:0] w, logic [3:0] be,
                                      logic rd, logic wr, logic ce);
      return '{a, w, be, rd, wr, ce, 1'b1};
   endfunction
   // expected word after a lane-masked write
   function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] be);
      for (int k = 0; k < 4; k++) if (be[k]) o[9*k+:9] = n[9*k+:9];
      return o;
   endfunction
   task automatic chk(string n, logic [35:0] s, logic [35:0] e);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wait_ready;
      for (int n = 0; n < 2000 && tileReady !== 1'b1; n++) @(posedge clk);
      chk("tileReady", tileReady, 1'b1);
   endtask
   // write: both channels offered together, each dropped once taken
   task automatic axw(logic [7:0] a, logic [31:0] w, output logic [1:0] rs);
      logic ta, tw, tb;
      ta = 0; tw = 0; tb = 0;
      @(posedge clk);
      s_axi_awaddr <= a; s_axi_wdata <= w; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      // only the watchdog ends a wait for the slave
      while (!tb) begin
         @(posedge clk);
         if (!ta && s_axi_awready) begin s_axi_awvalid <= 0; ta = 1; end
         else if (!tw && s_axi_wready) begin s_axi_wvalid <= 0; tw = 1; end
         else if (ta && tw && s_axi_bvalid) begin
            s_axi_bready <= 0; tb = 1; rs = s_axi_bresp;
         end
         if (!tw && s_axi_wready && ta) begin s_axi_wvalid <= 0; tw = 1; end
      end
   endtask
   task automatic axr(logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic ta, tb;
      ta = 0; tb = 0;
      @(posedge clk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      while (!tb) begin
         @(posedge clk);
         if (!ta && s_axi_arready) begin s_axi_arvalid <= 0; ta = 1; end
         else if (ta && s_axi_rvalid) begin
            s_axi_rready <= 0; tb = 1; v = s_axi_rdata; rs = s_axi_rresp;
         end
      end
   endtask
   initial begin
      repeat (6000) @(posedge clk);
      num_errors++;
      end_sim;
   end
   initial begin
      sys_rst = 1; s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0; s_axi_wstrb = 4'hF;
      s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0; s_axi_arvalid = 0; s_axi_rready = 0;
      nop = mk(0, 0, 0, 0, 0, 1);
      repeat (12) @(posedge clk);
      chk("rdataA", rdataA, 0);
      sys_rst <= 0;
      wait_ready;
      fab.op(nop, mk(250, 0, 0, 1, 0, 1)); @(negedge clk); chk("init", rdataB, IW);
      // write on a while b reads the previous word in the same cycle
      for (int i = 0; i < 9; i++) begin
         r = rnd(); ad = {6'h0, i[2:0], r[3:0]}; d = {r[7:4], rnd()};
         fab.op(mk(ad, d, 4'hF, 0, 1, 1), mk(pa, 0, 0, i > 0, 0, 1)); @(negedge clk);
         if (i > 0) chk("rdataB", rdataB, pd);
         pa = ad; pd = d;
      end
      fab.op(mk(200, '1, 4'hA, 0, 1, 1), nop);
      fab.op(nop, mk(200, 0, 0, 1, 0, 1)); @(negedge clk);
      chk("mask", rdataB, merge(IW, '1, 4'hA));
      fab.op(mk(200, 0, 4'hF, 0, 1, 0), mk(200, 0, 0, 1, 0, 1)); @(negedge clk);
      chk("ceIn", rdataB, merge(IW, '1, 4'hA));
      fab.op(mk(200, 36'h123456789, 4'hF, 1, 1, 1), nop); @(negedge clk);
      chk("samePort", rdataA, 36'h123456789);
      // read taken with the output enable low must leave the output alone
      fab.op(nop, '{13'h0C8, 36'h0, 4'h0, 1'b1, 1'b0, 1'b1, 1'b0}); @(negedge clk);
      chk("ceOut", rdataB, merge(IW, '1, 4'hA));
      fab.op(mk(200, 0, 4'hF, 0, 1, 1), mk(200, 0, 0, 1, 0, 1)); @(negedge clk);
      chk("crossOld", rdataB, 36'h123456789);
      axr(CTRL_OFS, r, rsp); chk("ctrl", r, CTRL_RESET);
      axw(CTRL_OFS, 32'h182, rsp); chk("bresp", rsp, RESP_OKAY);
      fab.op(mk(200, '1, 4'hF, 0, 1, 1), mk(200, 0, 0, 1, 0, 1)); @(negedge clk);
      chk("crossDc", rdataB, DONT_CARE_WORD);
      axw(STATUS_OFS, 0, rsp); chk("roResp", rsp, RESP_SLVERR);
      axr(8'h0C, r, rsp); chk("badResp", rsp, RESP_SLVERR);
      axr(STATUS_OFS, r, rsp); chk("ready", r[STAT_READY_BIT], 1'b1);
      // rom refuses writes, single port ignores b, fifo pushes on a and pops on b
      axw(CTRL_OFS, 32'h184, rsp);
      fab.op(mk(200, 0, 4'hF, 0, 1, 1), mk(250, 0, 0, 1, 0, 1)); @(negedge clk);
      chk("rom", rdataB, IW);
      axw(CTRL_OFS, 32'h380, rsp);
      fab.op(mk(200, 0, 4'hF, 0, 1, 0), mk(200, 0, 4'hF, 0, 1, 1));
      fab.op(mk(200, 0, 0, 1, 0, 1), nop); @(negedge clk);
      chk("spOnly", rdataA, '1);
      axw(CTRL_OFS, 32'h385, rsp);
      fab.op(mk(0, 36'hA, 4'hF, 0, 1, 1), nop);
      fab.op(mk(0, 36'hB, 4'hF, 0, 1, 1), nop);
      axr(STATUS_OFS, r, rsp); chk("fifoCnt", r[STAT_COUNT_LSB +: 14], 36'h2);
      fab.op(nop, mk(0, 0, 0, 1, 0, 1)); @(negedge clk); chk("pop", rdataB, 36'hA);
      // reload bit restarts the preload; b then sees the image word as old data
      axw(CTRL_OFS, 32'h782, rsp);
      wait_ready;
      fab.op(mk(200, 0, 4'hF, 0, 1, 1), mk(200, 0, 0, 1, 0, 1)); @(negedge clk);
      chk("ctrlLoad", rdataB, IW);
      @(posedge clk); sys_rst <= 1; @(negedge clk);
      chk("clrB", rdataB, 0);
      @(posedge clk); sys_rst <= 0;
      wait_ready;
      fab.op(nop, mk(200, 0, 0, 1, 0, 1)); @(negedge clk); chk("reload", rdataB, IW);
      end_sim;
   end
endmodule // sbr_tile_tb_top
